// ===== dv/srpm_board.sv
// board side: strap resistor and the far devices on the four shared pins
// assumes the bench sets strap_req and the far levels

`timescale 1ns/1ps

module srpm_board (
   input wire logic rst_b,
   input wire logic strap_req,
   output logic mux_strap_input,
   input wire logic [3:0] dev_out,
   input wire logic [3:0] dev_oe_b,
   input wire logic [3:0] ext_lvl,
   output logic [3:0] pin_in
);
   // *****************************************
   // strap and wires
   // *****************************************
   initial mux_strap_input = 1'h0;
   // strap only moves outside reset
   always @(rst_b or strap_req) if (rst_b === 1'h1) mux_strap_input = strap_req;
   // far device lets go while the pin is driven, so no contention
   assign pin_in = (dev_oe_b & ext_lvl) | (~dev_oe_b & dev_out);
endmodule

// ===== dv/srpm_checker.sv
// concurrent checks on the strap mux ports of srpm_top
// assumes one clock domain and rst_b as the only reset

`timescale 1ns/1ps

module srpm_checker (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic mux_strap_input,
   input wire logic mux_select_serial,
   input wire logic mux_locked,
   input wire logic shared_pin_zero_oe_b,
   input wire logic shared_pin_one_out,
   input wire logic shared_pin_one_oe_b,
   input wire logic shared_pin_two_oe_b,
   input wire logic shared_pin_three_oe_b,
   input wire logic uart_tx_data,
   input wire logic general_io_line_three_drive,
   input wire logic general_io_line_five_drive,
   input wire logic serial_tx_clock_drive,
   input wire logic serial_rx_clock_drive,
   input wire logic serial_tx_frame_sync_drive,
   input wire logic serial_rx_frame_sync_drive
);
   // *****************************************
   // properties
   // *****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // depth 2 skips the edge where requests first reach the pins
   property p_lock; $rose(rst_b) |-> ##[1:6] mux_locked; endproperty
   a_lock: assert property (p_lock) else $error("lock late");
   property p_sel; $rose(mux_locked) |-> mux_select_serial == $past(mux_strap_input, 2); endproperty
   a_sel: assert property (p_sel) else $error("select wrong");
   property p_hold; mux_locked && $past(mux_locked) |-> $stable(mux_select_serial); endproperty
   a_hold: assert property (p_hold) else $error("select moved");
   property p_pin0; $past(mux_locked, 2) |-> shared_pin_zero_oe_b ==
      !(mux_select_serial ? $past(serial_tx_clock_drive) : $past(general_io_line_three_drive)); endproperty
   a_pin0: assert property (p_pin0) else $error("pin zero enable");
   property p_pin1; $past(mux_locked, 2) |-> shared_pin_one_oe_b ==
      (mux_select_serial && !$past(serial_rx_clock_drive)); endproperty
   a_pin1: assert property (p_pin1) else $error("pin one enable");
   property p_tx; $past(mux_locked, 2) && !mux_select_serial |-> shared_pin_one_out == $past(uart_tx_data); endproperty
   a_tx: assert property (p_tx) else $error("pin one level");
   property p_pin2; $past(mux_locked, 2) |-> shared_pin_two_oe_b ==
      !(mux_select_serial ? $past(serial_tx_frame_sync_drive) : $past(general_io_line_five_drive)); endproperty
   a_pin2: assert property (p_pin2) else $error("pin two enable");
   property p_pin3; $past(mux_locked, 2) |-> shared_pin_three_oe_b ==
      !(mux_select_serial && $past(serial_rx_frame_sync_drive)); endproperty
   a_pin3: assert property (p_pin3) else $error("pin three enable");
   property p_dflt; !mux_locked |-> shared_pin_zero_oe_b && shared_pin_two_oe_b && shared_pin_three_oe_b; endproperty
   a_dflt: assert property (p_dflt) else $error("default drive");
   property p_idle; !mux_locked && !mux_strap_input |-> !shared_pin_one_oe_b && shared_pin_one_out; endproperty
   a_idle: assert property (p_idle) else $error("transmit idle");
   c_ser: cover property ($rose(mux_locked) && mux_select_serial);
   c_gp: cover property ($rose(mux_locked) && !mux_select_serial);
   c_drv: cover property ($past(mux_locked, 2) && !shared_pin_zero_oe_b);
endmodule

bind srpm_top srpm_checker u_chk (.clk(clk), .rst_b(rst_b), .mux_strap_input(mux_strap_input),
   .mux_select_serial(mux_select_serial), .mux_locked(mux_locked), .shared_pin_zero_oe_b(shared_pin_zero_oe_b),
   .shared_pin_one_out(shared_pin_one_out), .shared_pin_one_oe_b(shared_pin_one_oe_b),
   .shared_pin_two_oe_b(shared_pin_two_oe_b), .shared_pin_three_oe_b(shared_pin_three_oe_b),
   .uart_tx_data(uart_tx_data), .general_io_line_three_drive(general_io_line_three_drive),
   .general_io_line_five_drive(general_io_line_five_drive), .serial_tx_clock_drive(serial_tx_clock_drive),
   .serial_rx_clock_drive(serial_rx_clock_drive), .serial_tx_frame_sync_drive(serial_tx_frame_sync_drive),
   .serial_rx_frame_sync_drive(serial_rx_frame_sync_drive));

// ===== dv/tb_serial_port2_reset_strap_pin_mux.sv
// self-checking bench for srpm_top with the board model
// assumes the checker is bound in from its own file

`timescale 1ns/1ps

module tb_serial_port2_reset_strap_pin_mux;
   logic clk = 1'h0;
   logic rst_b, strap_req, strap, g3o, g3d, g5o, g5d, utx, stco, stcd, srco, srcd, stfo, stfd, srfo, srfd;
   logic g3i, g5i, urx, stci, srci, stfi, srfi, sel, lock;
   logic [3:0] p_out, p_oe_b, pin_in, ext;
   int fails = 0;
   int check_count = 0;
   always #4 clk = ~clk;
   srpm_board u_board (.rst_b(rst_b), .strap_req(strap_req), .mux_strap_input(strap), .dev_out(p_out),
      .dev_oe_b(p_oe_b), .ext_lvl(ext), .pin_in(pin_in));
   srpm_top DUT (.clk(clk), .rst_b(rst_b), .mux_strap_input(strap),
      .shared_pin_zero_in(pin_in[0]), .shared_pin_zero_out(p_out[0]), .shared_pin_zero_oe_b(p_oe_b[0]),
      .shared_pin_one_in(pin_in[1]), .shared_pin_one_out(p_out[1]), .shared_pin_one_oe_b(p_oe_b[1]),
      .shared_pin_two_in(pin_in[2]), .shared_pin_two_out(p_out[2]), .shared_pin_two_oe_b(p_oe_b[2]),
      .shared_pin_three_in(pin_in[3]), .shared_pin_three_out(p_out[3]), .shared_pin_three_oe_b(p_oe_b[3]),
      .general_io_line_three_in(g3i), .general_io_line_three_out(g3o), .general_io_line_three_drive(g3d),
      .general_io_line_five_in(g5i), .general_io_line_five_out(g5o), .general_io_line_five_drive(g5d),
      .uart_tx_data(utx), .uart_rx_data(urx),
      .serial_tx_clock_in(stci), .serial_tx_clock_out(stco), .serial_tx_clock_drive(stcd),
      .serial_rx_clock_in(srci), .serial_rx_clock_out(srco), .serial_rx_clock_drive(srcd),
      .serial_tx_frame_sync_in(stfi), .serial_tx_frame_sync_out(stfo), .serial_tx_frame_sync_drive(stfd),
      .serial_rx_frame_sync_in(srfi), .serial_rx_frame_sync_out(srfo), .serial_rx_frame_sync_drive(srfd),
      .mux_select_serial(sel), .mux_locked(lock));

   // *****************************************
   // helpers
   // *****************************************
   task automatic chk(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic idle();
      {g3o, g3d, g5o, g5d, stco, stcd, srco, srcd, stfo, stfd, srfo, srfd} = 12'h0;
      utx = 1'h1;
      ext = 4'h0;
      step(3);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // *****************************************
   // scenarios
   // *****************************************
   task automatic t_reset(input logic s);
      int i;
      strap_req = s;
      step(1);
      rst_b = 1'h0;
      step(4);
      rst_b = 1'h1;
      step(1);
      chk("lock early", 1'h0, lock);
      chk("pin0 oe", 1'h1, p_oe_b[0]);
      chk("pin1 oe", s, p_oe_b[1]);
      chk("pin1 out", !s, p_out[1]);
      i = 0;
      while (lock !== 1'h1 && i < 10) begin
         step(1);
         i++;
      end
      chk("lock", 1'h1, lock);
      chk("select", s, sel);
      step(2);
      chk("pin2 oe", 1'h1, p_oe_b[2]);
      chk("pin3 oe", 1'h1, p_oe_b[3]);
      chk("pin1 idle", s, p_oe_b[1]);
      $display("test reset done");
   endtask
   task automatic t_gpio();
      {g3d, g3o, stcd, stco, g5d, srfd, srfo} = 7'h7F;
      utx = 1'h0;
      g5o = 1'h1;
      ext = 4'h8;
      // pin loop back: one edge to the pin, two to sync, one to register
      step(4);
      chk("pin0 oe", 1'h0, p_oe_b[0]);
      chk("line three in", 1'h1, g3i);
      chk("tx clock in", 1'h0, stci);
      chk("pin1 out", 1'h0, p_out[1]);
      chk("pin2 oe", 1'h0, p_oe_b[2]);
      chk("pin2 out", 1'h1, p_out[2]);
      chk("pin3 oe", 1'h1, p_oe_b[3]);
      chk("uart rx", 1'h1, urx);
      chk("rx sync in", 1'h0, srfi);
      strap_req = 1'h1;
      step(4);
      chk("select kept", 1'h0, sel);
      idle();
      $display("test gpio done");
   endtask
   task automatic t_serial();
      {stcd, stco, stfd, g3d, g5d, g5o} = 6'h3F;
      {stfo, g3o, utx} = 3'h0;
      ext = 4'hA;
      step(3);
      chk("pin0 oe", 1'h0, p_oe_b[0]);
      chk("pin0 out", 1'h1, p_out[0]);
      chk("line three in", 1'h0, g3i);
      chk("pin1 oe", 1'h1, p_oe_b[1]);
      chk("rx clock in", 1'h1, srci);
      chk("pin2 oe", 1'h0, p_oe_b[2]);
      chk("pin2 out", 1'h0, p_out[2]);
      chk("pin3 oe", 1'h1, p_oe_b[3]);
      chk("rx sync in", 1'h1, srfi);
      chk("uart rx", 1'h0, urx);
      // rx clock and rx sync now drive their pins
      {srcd, srco, srfd, srfo} = 4'hF;
      step(2);
      chk("pin1 serial oe", 1'h0, p_oe_b[1]);
      chk("pin1 serial out", 1'h1, p_out[1]);
      chk("pin3 serial oe", 1'h0, p_oe_b[3]);
      chk("pin3 serial out", 1'h1, p_out[3]);
      strap_req = 1'h0;
      step(4);
      chk("select kept", 1'h1, sel);
      idle();
      $display("test serial done");
   endtask

   initial begin
      rst_b = 1'h0;
      {g3o, g3d, g5o, g5d, stco, stcd, srco, srcd, stfo, stfd, srfo, srfd} = 12'h0;
      utx = 1'h1;
      ext = 4'h0;
      t_reset(1'h0);
      t_gpio();
      t_reset(1'h1);
      t_serial();
      t_reset(1'h0);
      wrap_up();
   end
   // whole run is near 56 cycles
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      wrap_up();
   end
endmodule

// ===== rtl/srpm_pin_cell.sv
// one shared pin: picks between a primary and an alternate function
// assumes use_alt is stable whenever force_default is low

`timescale 1ns/1ps

module srpm_pin_cell
   import srpm_pkg::*;
#(
   parameter logic PRIM_DEF_DRIVE = 1'h0,
   parameter logic PRIM_DEF_LEVEL = 1'h0,
   parameter logic ALT_DEF_DRIVE = 1'h0,
   parameter logic ALT_DEF_LEVEL = 1'h0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic use_alt,
   input wire logic force_default,
   input wire logic pin_in,
   output logic pin_out_q,
   output logic pin_oe_b_q,
   input wire logic prim_out,
   input wire logic prim_drive,
   output logic prim_in_q,
   input wire logic alt_out,
   input wire logic alt_drive,
   output logic alt_in_q
);

   // *********************************************
   // pin driver
   // *********************************************
   logic drive;
   logic pin_out_d;
   logic pin_oe_b_d;

   always_comb begin
      drive = SRPM_DRIVE_OFF;
      pin_out_d = SRPM_LEVEL_HIGH;
      if (force_default) begin
         drive = use_alt ? ALT_DEF_DRIVE : PRIM_DEF_DRIVE;
         pin_out_d = use_alt ? ALT_DEF_LEVEL : PRIM_DEF_LEVEL;
      end else if (use_alt) begin
         drive = alt_drive;
         pin_out_d = alt_out;
      end else begin
         drive = prim_drive;
         pin_out_d = prim_out;
      end
      pin_oe_b_d = ~drive;
   end

   // no reset here: the defaults must reach the pin while reset is still low
   always_ff @(posedge clk) begin
      pin_out_q <= pin_out_d;
      pin_oe_b_q <= pin_oe_b_d;
   end

   // *********************************************
   // pin receiver
   // *********************************************
   logic in_s1_q;
   logic in_s2_q;
   logic prim_in_d;
   logic alt_in_d;

   always_comb begin
      prim_in_d = use_alt ? SRPM_LEVEL_LOW : in_s2_q;
      alt_in_d = use_alt ? in_s2_q : SRPM_LEVEL_LOW;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_s1_q <= SRPM_SYNC_RST;
         in_s2_q <= SRPM_SYNC_RST;
         prim_in_q <= SRPM_LEVEL_LOW;
         alt_in_q <= SRPM_LEVEL_LOW;
      end else begin
         in_s1_q <= pin_in;
         in_s2_q <= in_s1_q;
         prim_in_q <= prim_in_d;
         alt_in_q <= alt_in_d;
      end
   end

endmodule

// ===== rtl/srpm_pkg.sv
// constants shared by the shared-pin strap mux and its pin cells
// assumes one 125 MHz clock domain and an active-low board reset

package srpm_pkg;

   // *********************************************
   // clock and sequencing
   // *********************************************
   localparam int SRPM_CLK_MHZ = 125;
   localparam int SRPM_SYNC_STAGES = 2;
   // cycles spent in the lock phase; the defaults stay forced one cycle more after the reset copy rises
   localparam int SRPM_LOCK_CYCLES = 1;

   // *********************************************
   // pin indices
   // *********************************************
   localparam int SRPM_PIN_ZERO = 0;
   localparam int SRPM_PIN_ONE = 1;
   localparam int SRPM_PIN_TWO = 2;
   localparam int SRPM_PIN_THREE = 3;
   localparam int SRPM_PIN_COUNT = 4;

   // *********************************************
   // values after reset
   // *********************************************
   localparam logic SRPM_SEL_GPIO = 1'h0;
   localparam logic SRPM_SEL_SERIAL = 1'h1;
   localparam logic SRPM_DRIVE_OFF = 1'h0;
   localparam logic SRPM_DRIVE_ON = 1'h1;
   localparam logic SRPM_LEVEL_LOW = 1'h0;
   localparam logic SRPM_LEVEL_HIGH = 1'h1;
   localparam logic SRPM_UART_TX_IDLE = 1'h1;
   localparam logic SRPM_SYNC_RST = 1'h0;
   localparam logic SRPM_STATUS_RST = 1'h0;

   // *********************************************
   // sequencing states
   // *********************************************
   typedef enum logic [2:0] {
      SRPM_PH_HOLD = 3'h1,
      SRPM_PH_LOCK = 3'h2,
      SRPM_PH_RUN = 3'h4
   } srpm_phase_t;

endpackage

// ===== rtl/srpm_top.sv
// strap-selected function mux for the four shared pins of serial port two
// assumes the board holds the strap steady through reset and the peripherals
// behind it run on the same clock

`timescale 1ns/1ps

module srpm_top
   import srpm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic mux_strap_input,
   input wire logic shared_pin_zero_in,
   output logic shared_pin_zero_out,
   output logic shared_pin_zero_oe_b,
   input wire logic shared_pin_one_in,
   output logic shared_pin_one_out,
   output logic shared_pin_one_oe_b,
   input wire logic shared_pin_two_in,
   output logic shared_pin_two_out,
   output logic shared_pin_two_oe_b,
   input wire logic shared_pin_three_in,
   output logic shared_pin_three_out,
   output logic shared_pin_three_oe_b,
   output logic general_io_line_three_in,
   input wire logic general_io_line_three_out,
   input wire logic general_io_line_three_drive,
   output logic general_io_line_five_in,
   input wire logic general_io_line_five_out,
   input wire logic general_io_line_five_drive,
   input wire logic uart_tx_data,
   output logic uart_rx_data,
   output logic serial_tx_clock_in,
   input wire logic serial_tx_clock_out,
   input wire logic serial_tx_clock_drive,
   output logic serial_rx_clock_in,
   input wire logic serial_rx_clock_out,
   input wire logic serial_rx_clock_drive,
   output logic serial_tx_frame_sync_in,
   input wire logic serial_tx_frame_sync_out,
   input wire logic serial_tx_frame_sync_drive,
   output logic serial_rx_frame_sync_in,
   input wire logic serial_rx_frame_sync_out,
   input wire logic serial_rx_frame_sync_drive,
   output logic mux_select_serial,
   output logic mux_locked
);

   // *********************************************
   // reset release
   // *********************************************
   logic rst_s1_q;
   logic rst_s2_q;
   logic rst_n;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_q <= SRPM_SYNC_RST;
         rst_s2_q <= SRPM_SYNC_RST;
      end else begin
         rst_s1_q <= 1'h1;
         rst_s2_q <= rst_s1_q;
      end
   end

   assign rst_n = rst_s2_q;

   // *********************************************
   // strap capture
   // *********************************************
   // the strap synchroniser has no reset: it must keep sampling while reset is low
   logic strap_s1_q;
   logic strap_s2_q;

   always_ff @(posedge clk) begin
      strap_s1_q <= mux_strap_input;
      strap_s2_q <= strap_s1_q;
   end

   srpm_phase_t phase_q;
   srpm_phase_t phase_d;
   logic sel_q;
   logic sel_d;
   logic [1:0] lock_cnt_q;
   logic [1:0] lock_cnt_d;

   always_comb begin
      sel_d = sel_q;
      phase_d = phase_q;
      lock_cnt_d = lock_cnt_q;
      case (phase_q)
         SRPM_PH_HOLD: begin
            sel_d = strap_s2_q;
            phase_d = SRPM_PH_LOCK;
            lock_cnt_d = 2'(SRPM_LOCK_CYCLES - 1);
         end
         SRPM_PH_LOCK: begin
            if (lock_cnt_q == 2'h0) begin
               phase_d = SRPM_PH_RUN;
            end else begin
               lock_cnt_d = lock_cnt_q - 2'h1;
            end
         end
         SRPM_PH_RUN: begin
            sel_d = sel_q;
         end
         default: begin
            phase_d = SRPM_PH_HOLD;
         end
      endcase
   end

   // sel has no reset so that the reset phase itself can load it;
   // it is frozen once the phase leaves hold, which only reset re-enters
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sel_q <= strap_s2_q;
      end else begin
         sel_q <= sel_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= SRPM_PH_HOLD;
         lock_cnt_q <= 2'h0;
      end else begin
         phase_q <= phase_d;
         lock_cnt_q <= lock_cnt_d;
      end
   end

   logic force_default;

   assign force_default = (phase_q != SRPM_PH_RUN);

   // *********************************************
   // status
   // *********************************************
   logic sel_out_d;
   logic locked_d;

   always_comb begin
      sel_out_d = mux_select_serial;
      locked_d = (phase_d == SRPM_PH_RUN);
      if (phase_q == SRPM_PH_LOCK) begin
         sel_out_d = sel_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mux_select_serial <= SRPM_STATUS_RST;
         mux_locked <= SRPM_STATUS_RST;
      end else begin
         mux_select_serial <= sel_out_d;
         mux_locked <= locked_d;
      end
   end

   // *********************************************
   // shared pins
   // *********************************************
   // general line three or tx clock, both idle as inputs
   srpm_pin_cell #(
      .PRIM_DEF_DRIVE(SRPM_DRIVE_OFF),
      .PRIM_DEF_LEVEL(SRPM_LEVEL_LOW),
      .ALT_DEF_DRIVE(SRPM_DRIVE_OFF),
      .ALT_DEF_LEVEL(SRPM_LEVEL_LOW)
   ) u_pin_zero (
      .clk(clk),
      .rst_n(rst_n),
      .use_alt(sel_q),
      .force_default(force_default),
      .pin_in(shared_pin_zero_in),
      .pin_out_q(shared_pin_zero_out),
      .pin_oe_b_q(shared_pin_zero_oe_b),
      .prim_out(general_io_line_three_out),
      .prim_drive(general_io_line_three_drive),
      .prim_in_q(general_io_line_three_in),
      .alt_out(serial_tx_clock_out),
      .alt_drive(serial_tx_clock_drive),
      .alt_in_q(serial_tx_clock_in)
   );

   // uart transmit is an output only and idles high, also during reset
   srpm_pin_cell #(
      .PRIM_DEF_DRIVE(SRPM_DRIVE_ON),
      .PRIM_DEF_LEVEL(SRPM_UART_TX_IDLE),
      .ALT_DEF_DRIVE(SRPM_DRIVE_OFF),
      .ALT_DEF_LEVEL(SRPM_LEVEL_LOW)
   ) u_pin_one (
      .clk(clk),
      .rst_n(rst_n),
      .use_alt(sel_q),
      .force_default(force_default),
      .pin_in(shared_pin_one_in),
      .pin_out_q(shared_pin_one_out),
      .pin_oe_b_q(shared_pin_one_oe_b),
      .prim_out(uart_tx_data),
      .prim_drive(SRPM_DRIVE_ON),
      .prim_in_q(),
      .alt_out(serial_rx_clock_out),
      .alt_drive(serial_rx_clock_drive),
      .alt_in_q(serial_rx_clock_in)
   );

   srpm_pin_cell #(
      .PRIM_DEF_DRIVE(SRPM_DRIVE_OFF),
      .PRIM_DEF_LEVEL(SRPM_LEVEL_LOW),
      .ALT_DEF_DRIVE(SRPM_DRIVE_OFF),
      .ALT_DEF_LEVEL(SRPM_LEVEL_LOW)
   ) u_pin_two (
      .clk(clk),
      .rst_n(rst_n),
      .use_alt(sel_q),
      .force_default(force_default),
      .pin_in(shared_pin_two_in),
      .pin_out_q(shared_pin_two_out),
      .pin_oe_b_q(shared_pin_two_oe_b),
      .prim_out(general_io_line_five_out),
      .prim_drive(general_io_line_five_drive),
      .prim_in_q(general_io_line_five_in),
      .alt_out(serial_tx_frame_sync_out),
      .alt_drive(serial_tx_frame_sync_drive),
      .alt_in_q(serial_tx_frame_sync_in)
   );

   // uart receive never drives the pin
   srpm_pin_cell #(
      .PRIM_DEF_DRIVE(SRPM_DRIVE_OFF),
      .PRIM_DEF_LEVEL(SRPM_LEVEL_LOW),
      .ALT_DEF_DRIVE(SRPM_DRIVE_OFF),
      .ALT_DEF_LEVEL(SRPM_LEVEL_LOW)
   ) u_pin_three (
      .clk(clk),
      .rst_n(rst_n),
      .use_alt(sel_q),
      .force_default(force_default),
      .pin_in(shared_pin_three_in),
      .pin_out_q(shared_pin_three_out),
      .pin_oe_b_q(shared_pin_three_oe_b),
      .prim_out(SRPM_LEVEL_LOW),
      .prim_drive(SRPM_DRIVE_OFF),
      .prim_in_q(uart_rx_data),
      .alt_out(serial_rx_frame_sync_out),
      .alt_drive(serial_rx_frame_sync_drive),
      .alt_in_q(serial_rx_frame_sync_in)
   );

endmodule
